// ### acp_gain_chan.sv
// per-channel gain holder with zero-cross update
`timescale 1ns/1ps
`default_nettype none
module acp_gain_chan
    import acp_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // control from the register bank
    input wire logic i_hold_mute,
    input wire logic i_load_now,
    input wire logic i_arm,
    input wire logic [6:0] i_target,
    input wire logic i_zero_cross,
    input wire logic i_timeout,
    // state
    output logic [6:0] o_gain,
    output logic o_pending
);
    // RULE16 apply at zero cross or timeout
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gain <= 7'h00;
            o_pending <= 1'b0;
        end else if (i_hold_mute) begin
            o_gain <= ACP_RST_GAIN[6:0];
            o_pending <= 1'b0;
        end else if (i_load_now) begin
            o_gain <= i_target;
            o_pending <= 1'b0;
        end else if (i_arm) begin
            // RULE20 rewrite keeps current gain
            o_pending <= 1'b1;
        end else if (o_pending && (i_zero_cross || i_timeout)) begin
            o_gain <= i_target;
            o_pending <= 1'b0;
        end
    end

    property p_apply;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_pending && (i_zero_cross || i_timeout) && !i_hold_mute && !i_load_now && !i_arm
        |=> o_gain == $past(i_target) && !o_pending;
    endproperty
    a_apply: assert property (p_apply) else $error("pending gain not applied"); // RULE16
endmodule
`default_nettype wire

// ### acp_host_model.sv
// behavioural host that drives the three-wire control link
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
    // link pins toward the device
    output logic o_control_clock,
    output logic o_chip_select_n,
    output logic o_control_data_in
);
    // half of the 80 ns control clock period
    localparam time HALF = 40;
    initial begin
        // clock stands still high outside frames
        o_control_clock = 1'b1;
        o_chip_select_n = 1'b1;
        o_control_data_in = 1'b0;
    end
    // one frame; an edge count other than sixteen only for refusal cases
    task automatic send(input logic [4:0] addr, input logic [7:0] data, input int edges);
        logic [15:0] word;
        word = {data, addr, 3'b111};
        #7;
        o_chip_select_n = 1'b0;
        #50;
        for (int i = 0; i < edges; i++) begin
            // shift on fall, device samples rise
            o_control_clock = 1'b0;
            o_control_data_in = (i < 16) ? word[i] : 1'b0;
            #HALF;
            o_control_clock = 1'b1;
            #HALF;
        end
        #50;
        o_chip_select_n = 1'b1;
        // released line shows the inverse, not a stale bit
        o_control_data_in = ~o_control_data_in;
        // chip select held high between frames
        #200;
    endtask
endmodule
`default_nettype wire

// ### acp_link_rx.sv
// serial receiver running on the control clock
`timescale 1ns/1ps
`default_nettype none
module acp_link_rx
    import acp_pkg::*;
(
    // link pins
    input wire logic i_control_clock,
    input wire logic i_chip_select_n,
    input wire logic i_control_data_in,
    // system reset
    input wire logic i_sys_rst,
    // frame, held stable while chip select is high
    output acp_frame_t o_frame
);
    logic open_r; // an edge has been seen in this frame
    logic [15:0] shift_r; // bits in arrival order, first at bit 0
    logic [4:0] edges_r; // saturating rising edge count
    logic tgl_r; // flips once per frame

    // chip select high ends the frame without needing a clock edge
    // system reset clears it too, so the first frame never meets an unknown flag
    always_ff @(posedge i_control_clock or posedge i_chip_select_n or posedge i_sys_rst) begin
        if (i_chip_select_n || i_sys_rst) begin
            open_r <= 1'b0;
        end else begin
            open_r <= 1'b1;
        end
    end

    // RULE2 sample on rising edge
    // data survives chip select high so the system side can read it
    always_ff @(posedge i_control_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_r <= 16'h0000;
            edges_r <= 5'h00;
            tgl_r <= 1'b0;
        end else if (!open_r) begin
            shift_r <= {i_control_data_in, shift_r[15:1]};
            edges_r <= 5'h01;
            tgl_r <= ~tgl_r;
        end else begin
            shift_r <= {i_control_data_in, shift_r[15:1]};
            // RULE23 extra edges saturate
            edges_r <= (edges_r == ACP_EDGES_OVER) ? ACP_EDGES_OVER : edges_r + 5'h01;
        end
    end

    // RULE1 opcode, address, data in order
    assign o_frame = '{data: shift_r[15:8], addr: shift_r[7:3], opcode: shift_r[2:0],
                       edges: edges_r, tgl: tgl_r};

    property p_shift_in;
        @(posedge i_control_clock) disable iff (i_sys_rst)
        1'b1 |=> shift_r[15] == $past(i_control_data_in);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("control bit not sampled"); // RULE2
    property p_edge_cap;
        @(posedge i_control_clock) disable iff (i_sys_rst)
        open_r |=> edges_r <= ACP_EDGES_OVER && edges_r != 5'h00;
    endproperty
    a_edge_cap: assert property (p_edge_cap) else $error("edge count out of range"); // RULE23
endmodule
`default_nettype wire

// ### acp_pkg.sv
// constants and carrier types for the converter control port
`default_nettype none
package acp_pkg;
    // register offsets
    localparam logic [4:0] ACP_ADDR_INPUT_SELECT = 5'h00;
    localparam logic [4:0] ACP_ADDR_POWER = 5'h01;
    localparam logic [4:0] ACP_ADDR_MIX_FORMAT = 5'h02;
    localparam logic [4:0] ACP_ADDR_GAIN = 5'h03;
    // frame layout
    localparam logic [4:0] ACP_FRAME_EDGES = 5'h10;
    localparam logic [4:0] ACP_EDGES_OVER = 5'h11;
    // reset values
    localparam logic [7:0] ACP_RST_INPUT_SELECT = 8'h05;
    localparam logic [7:0] ACP_RST_POWER = 8'h03;
    localparam logic [7:0] ACP_RST_MIX_FORMAT = 8'h30;
    localparam logic [7:0] ACP_RST_GAIN = 8'h00;
    // writable bits, the rest read back as zero
    localparam logic [7:0] ACP_MASK_INPUT_SELECT = 8'h1F;
    localparam logic [7:0] ACP_MASK_POWER = 8'h03;
    localparam logic [7:0] ACP_MASK_MIX_FORMAT = 8'hF2;
    // field positions
    localparam int ACP_BIT_HPF_BYPASS = 4;
    localparam int ACP_BIT_GAIN_AMP_PWR = 0;
    localparam int ACP_BIT_CONV_PWR = 1;
    localparam int ACP_BIT_FORMAT = 1;
    localparam int ACP_LSB_TIMEOUT = 4;
    localparam int ACP_LSB_MIX = 6;
    localparam int ACP_BIT_ZC_ENABLE = 7;
    // gain limits and zero-cross timeout base in sample periods
    localparam logic [6:0] ACP_GAIN_MAX = 7'h60;
    localparam logic [11:0] ACP_TMO_BASE = 12'h100;

    // output routing modes
    typedef enum logic [1:0] {
        ACP_MIX_STEREO = 2'b00,
        ACP_MIX_AVERAGE = 2'b01,
        ACP_MIX_LEFT = 2'b10,
        ACP_MIX_RIGHT = 2'b11
    } acp_mix_t;
    // audio data formats
    typedef enum logic {
        ACP_FMT_MSB_JUSTIFIED = 1'b0,
        ACP_FMT_INTER_IC = 1'b1
    } acp_fmt_t;
    // one received control frame with its edge count
    typedef struct packed {
        logic [7:0] data;
        logic [4:0] addr;
        logic [2:0] opcode;
        logic [4:0] edges;
        logic tgl;
    } acp_frame_t;
    // decoded control fields
    typedef struct packed {
        logic highpass_bypass;
        logic right_input_b_en;
        logic right_input_a_en;
        logic left_input_b_en;
        logic left_input_a_en;
        logic gain_amp_power;
        logic converter_power;
        acp_mix_t mix_select;
        logic [1:0] zero_cross_timeout_sel;
        acp_fmt_t serial_format_sel;
        logic zero_cross_enable;
    } acp_ctrl_t;
endpackage
`default_nettype wire

// ### acp_regs.sv
// control port register bank with zero-cross gain update
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: frame is opcode, address, data, LSB first
// RULE2: host shifts on fall, device samples rise
// RULE3: write commits when chip select rises
// RULE4: host keeps chip select high when idle
// RULE5: only addresses 00H to 03H written
// RULE6: host gives sixteen clock edges per frame
// RULE7: power-down pin low holds reset values
// RULE8: bit 4 of 00H bypasses highpass filter
// RULE9: bits 0-3 of 00H enable inputs
// RULE10: 01H bits power amplifier and converter
// RULE11: pin low or both bits clear: powered down
// RULE12: mixing field selects stereo, average, left, right
// RULE13: timeout 256 to 2048 sample periods
// RULE14: format bit picks justified or inter-IC
// RULE15: converter off ignores writes to 02H
// RULE16: armed gain applies at crossing or timeout
// RULE17: zero-cross off or converter off: immediate
// RULE18: gain code tops out at 60H
// RULE19: amplifier off ignores gain writes
// RULE20: rewrite restarts timeout, channels keep gains
// RULE21: host waits one timeout between gain writes
// RULE22: host avoids 01H during calibration
// RULE23: frames without sixteen edges are discarded
module acp_regs
    import acp_pkg::*;
(
    // system clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // control link pins
    input wire logic i_control_clock,
    input wire logic i_chip_select_n,
    input wire logic i_control_data_in,
    // device pins and sample timebase
    input wire logic i_power_down_n,
    input wire logic i_channel_clock,
    // zero crossing flags from the comparators
    input wire logic i_left_zero_cross,
    input wire logic i_right_zero_cross,
    // decoded control fields
    output acp_ctrl_t o_ctrl,
    // power state
    output logic o_gain_amp_on,
    output logic o_converter_on,
    output logic o_all_powered_down,
    // applied gains
    output logic [6:0] o_left_gain,
    output logic [6:0] o_right_gain,
    output logic o_left_pending,
    output logic o_right_pending
);
    // synchroniser lanes
    localparam int SY_CSN = 0;
    localparam int SY_PDN = 1;
    localparam int SY_LR = 2;
    localparam int SY_ZL = 3;
    localparam int SY_ZR = 4;
    localparam logic [4:0] SY_RST = 5'h01; // chip select idles high

    acp_frame_t rx; // frame from the link domain
    logic [4:0] meta_r; // first stage, read only by sync_r
    logic [4:0] sync_r; // second stage
    logic csn_prev_r; // chip select one cycle back
    logic lr_prev_r; // channel clock one cycle back
    logic seen_tgl_r; // toggle of the last frame handled
    logic [7:0] r0_r; // input selection
    logic [7:0] r1_r; // power control
    logic [7:0] r2_r; // mix and format
    logic [7:0] r3_r; // gain and zero-cross enable
    logic [11:0] tmo_cnt_r; // sample periods left
    logic tmo_pulse_r; // timeout expired
    logic power_down_n; // synchronised power-down pin
    logic frame_end; // chip select rise seen
    logic fresh; // a new frame arrived since the last rise
    logic frame_ok; // complete and allowed frame
    logic wr0, wr1, wr2, wr3; // accepted writes
    logic [6:0] gain_clamped; // written code limited to the top
    logic [6:0] tgt; // target for both channels
    logic immediate; // gain bypasses zero-cross wait
    logic gain_load; // apply gain now
    logic gain_arm; // wait for crossing
    logic sample_tick; // one sample period elapsed

    // link-facing receiver
    acp_link_rx u_rx (
        .i_control_clock(i_control_clock),
        .i_chip_select_n(i_chip_select_n),
        .i_control_data_in(i_control_data_in),
        .i_sys_rst(i_sys_rst),
        .o_frame(rx)
    );

    // two-stage sync of every pin that leaves its own domain
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= SY_RST;
            sync_r <= SY_RST;
        end else begin
            meta_r <= {i_right_zero_cross, i_left_zero_cross, i_channel_clock,
                       i_power_down_n, i_chip_select_n};
            sync_r <= meta_r;
        end
    end

    // edge history for chip select and channel clock
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            csn_prev_r <= 1'b1;
            lr_prev_r <= 1'b0;
        end else begin
            csn_prev_r <= sync_r[SY_CSN];
            lr_prev_r <= sync_r[SY_LR];
        end
    end

    assign power_down_n = sync_r[SY_PDN];
    // RULE3 commit on chip select rise
    assign frame_end = sync_r[SY_CSN] && !csn_prev_r;
    // a chip select pulse with no clock leaves the toggle alone
    assign fresh = rx.tgl != seen_tgl_r;
    assign sample_tick = sync_r[SY_LR] && !lr_prev_r;
    // RULE23 exactly sixteen edges
    assign frame_ok = frame_end && fresh && power_down_n && rx.edges == ACP_FRAME_EDGES;

    // remember which frame was handled; the word is stable, since the host
    // gives no clock edge while chip select stays high
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            seen_tgl_r <= 1'b0;
        end else if (frame_end) begin
            seen_tgl_r <= rx.tgl;
        end
    end

    // address decode with power locks
    always_comb begin
        wr0 = 1'b0;
        wr1 = 1'b0;
        wr2 = 1'b0;
        wr3 = 1'b0;
        // RULE5 other addresses ignored
        if (!frame_ok) begin
            wr0 = 1'b0;
        end else if (rx.addr == ACP_ADDR_INPUT_SELECT) begin
            wr0 = 1'b1;
        end else if (rx.addr == ACP_ADDR_POWER) begin
            wr1 = 1'b1;
        end else if (rx.addr == ACP_ADDR_MIX_FORMAT) begin
            // RULE15 converter off locks 02H
            wr2 = r1_r[ACP_BIT_CONV_PWR];
        end else if (rx.addr == ACP_ADDR_GAIN) begin
            // RULE19 amplifier off locks gain
            wr3 = r1_r[ACP_BIT_GAIN_AMP_PWR];
        end
    end

    // RULE18 codes above the top clamp
    assign gain_clamped = (rx.data[6:0] > ACP_GAIN_MAX) ? ACP_GAIN_MAX : rx.data[6:0];
    assign tgt = wr3 ? gain_clamped : r3_r[6:0];
    // RULE17 immediate when zero-cross off or converter off
    assign immediate = !rx.data[ACP_BIT_ZC_ENABLE] || !r1_r[ACP_BIT_CONV_PWR];
    assign gain_load = wr3 && immediate;
    assign gain_arm = wr3 && !immediate;

    // register bank
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r0_r <= ACP_RST_INPUT_SELECT;
            r1_r <= ACP_RST_POWER;
            r2_r <= ACP_RST_MIX_FORMAT;
            r3_r <= ACP_RST_GAIN;
        end else if (!power_down_n) begin
            // RULE7 pin low holds reset
            r0_r <= ACP_RST_INPUT_SELECT;
            r1_r <= ACP_RST_POWER;
            r2_r <= ACP_RST_MIX_FORMAT;
            r3_r <= ACP_RST_GAIN;
        end else begin
            // RULE3 data lands at frame end
            if (wr0) begin
                r0_r <= rx.data & ACP_MASK_INPUT_SELECT;
            end
            if (wr1) begin
                r1_r <= rx.data & ACP_MASK_POWER;
            end
            if (wr2) begin
                r2_r <= rx.data & ACP_MASK_MIX_FORMAT;
            end
            if (wr3) begin
                r3_r <= {rx.data[ACP_BIT_ZC_ENABLE], gain_clamped};
            end
        end
    end

    // zero-cross timeout counter in sample periods
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tmo_cnt_r <= 12'h000;
            tmo_pulse_r <= 1'b0;
        end else if (!power_down_n) begin
            tmo_cnt_r <= 12'h000;
            tmo_pulse_r <= 1'b0;
        end else if (gain_arm) begin
            // RULE20 rewrite restarts count
            // RULE13 base shifted by code
            tmo_cnt_r <= ACP_TMO_BASE << r2_r[ACP_LSB_TIMEOUT +: 2];
            tmo_pulse_r <= 1'b0;
        end else if (sample_tick && tmo_cnt_r != 12'h000) begin
            tmo_cnt_r <= tmo_cnt_r - 12'h001;
            tmo_pulse_r <= tmo_cnt_r == 12'h001;
        end else begin
            tmo_pulse_r <= 1'b0;
        end
    end

    // left and right keep their own gain, so they may differ for a while
    acp_gain_chan u_left (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_hold_mute(!power_down_n),
        .i_load_now(gain_load),
        .i_arm(gain_arm),
        .i_target(tgt),
        .i_zero_cross(sync_r[SY_ZL]),
        .i_timeout(tmo_pulse_r),
        .o_gain(o_left_gain),
        .o_pending(o_left_pending)
    );
    acp_gain_chan u_right (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_hold_mute(!power_down_n),
        .i_load_now(gain_load),
        .i_arm(gain_arm),
        .i_target(tgt),
        .i_zero_cross(sync_r[SY_ZR]),
        .i_timeout(tmo_pulse_r),
        .o_gain(o_right_gain),
        .o_pending(o_right_pending)
    );

    // power state outputs
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gain_amp_on <= 1'b0;
            o_converter_on <= 1'b0;
            o_all_powered_down <= 1'b1;
        end else begin
            // RULE10 one bit per block
            // RULE11 pin overrides the bits
            o_gain_amp_on <= power_down_n && r1_r[ACP_BIT_GAIN_AMP_PWR];
            o_converter_on <= power_down_n && r1_r[ACP_BIT_CONV_PWR];
            o_all_powered_down <= !power_down_n || (r1_r & ACP_MASK_POWER) == 8'h00;
        end
    end

    // field fan-out straight from the register flops
    always_comb begin
        // RULE8 highpass bypass bit
        o_ctrl.highpass_bypass = r0_r[ACP_BIT_HPF_BYPASS];
        // RULE9 input enables
        o_ctrl.right_input_b_en = r0_r[3];
        o_ctrl.right_input_a_en = r0_r[2];
        o_ctrl.left_input_b_en = r0_r[1];
        o_ctrl.left_input_a_en = r0_r[0];
        o_ctrl.gain_amp_power = r1_r[ACP_BIT_GAIN_AMP_PWR];
        o_ctrl.converter_power = r1_r[ACP_BIT_CONV_PWR];
        // RULE12 routing mode
        o_ctrl.mix_select = acp_mix_t'(r2_r[ACP_LSB_MIX +: 2]);
        o_ctrl.zero_cross_timeout_sel = r2_r[ACP_LSB_TIMEOUT +: 2];
        // RULE14 data format
        o_ctrl.serial_format_sel = acp_fmt_t'(r2_r[ACP_BIT_FORMAT]);
        o_ctrl.zero_cross_enable = r3_r[ACP_BIT_ZC_ENABLE];
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence s_live_end;
        frame_end && fresh && power_down_n;
    endsequence
    sequence s_gain_now;
        gain_load;
    endsequence
    sequence s_gain_write;
        wr3;
    endsequence

    property p_unmapped;
        s_live_end and (rx.addr > ACP_ADDR_GAIN) |=> $stable({r0_r, r1_r, r2_r, r3_r});
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address wrote a register"); // RULE5
    property p_pdn_hold;
        !power_down_n |=> {r0_r, r1_r, r2_r, r3_r} ==
            {ACP_RST_INPUT_SELECT, ACP_RST_POWER, ACP_RST_MIX_FORMAT, ACP_RST_GAIN};
    endproperty
    a_pdn_hold: assert property (p_pdn_hold) else $error("registers not held at reset"); // RULE7
    property p_mix_lock;
        s_live_end and (rx.addr == ACP_ADDR_MIX_FORMAT && !r1_r[ACP_BIT_CONV_PWR]) |=> $stable(r2_r);
    endproperty
    a_mix_lock: assert property (p_mix_lock) else $error("locked mix register written"); // RULE15
    property p_gain_lock;
        s_live_end and (rx.addr == ACP_ADDR_GAIN && !r1_r[ACP_BIT_GAIN_AMP_PWR])
        |=> $stable(r3_r) ##1 $stable(o_left_gain);
    endproperty
    a_gain_lock: assert property (p_gain_lock) else $error("locked gain register written"); // RULE19
    property p_commit;
        $changed(r0_r) && $past(power_down_n) |-> $past(frame_end);
    endproperty
    a_commit: assert property (p_commit) else $error("register changed outside frame end"); // RULE3
    property p_immediate;
        s_gain_now |=> o_left_gain == $past(tgt) && o_right_gain == $past(tgt);
    endproperty
    a_immediate: assert property (p_immediate) else $error("gain not applied at once"); // RULE17
    property p_tmo_load;
        gain_arm |=> tmo_cnt_r == (ACP_TMO_BASE << $past(r2_r[5:4])) && o_left_pending;
    endproperty
    a_tmo_load: assert property (p_tmo_load) else $error("timeout not restarted"); // RULE20
    property p_bad_count;
        s_live_end and (rx.edges != ACP_FRAME_EDGES) |=> $stable({r0_r, r1_r, r2_r, r3_r});
    endproperty
    a_bad_count: assert property (p_bad_count) else $error("short or long frame committed"); // RULE23
    property p_power;
        !power_down_n |=> !o_converter_on && !o_gain_amp_on && o_all_powered_down;
    endproperty
    a_power: assert property (p_power) else $error("powered while pin low"); // RULE11
    // a code above the top level is stored as the top level
    property p_clamp;
        s_gain_write and (rx.data[6:0] > ACP_GAIN_MAX) |=> r3_r[6:0] == ACP_GAIN_MAX;
    endproperty
    a_clamp: assert property (p_clamp) else $error("gain code above top stored"); // RULE18
    // with the pin high each block follows its own power bit
    property p_block_power;
        power_down_n |=> o_gain_amp_on == $past(r1_r[ACP_BIT_GAIN_AMP_PWR])
            && o_converter_on == $past(r1_r[ACP_BIT_CONV_PWR]);
    endproperty
    a_block_power: assert property (p_block_power) else $error("block power not following its bit"); // RULE10
endmodule
`default_nettype wire

// ### adc_control_port_regs_bench.sv
// self-checking bench for the converter control register bank
`timescale 1ns/1ps
`default_nettype none
module adc_control_port_regs_bench;
    import acp_pkg::*;
    // stimulus
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pdn_n = 1'b1;
    logic ch_clk = 1'b0;
    logic lzc = 1'b0;
    logic rzc = 1'b0;
    // link wires from the host model
    wire control_clock;
    wire chip_select_n;
    wire cdi;
    // observed outputs
    acp_ctrl_t ctrl;
    logic gamp_on, conv_on, all_pd, lp, rp;
    logic [6:0] lg, rg;
    // shadow of the register bytes, bookkeeping
    logic [7:0] sh [0:3];
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int ch_div = 0;

    acp_host_model host (.o_control_clock(control_clock), .o_chip_select_n(chip_select_n), .o_control_data_in(cdi));
    acp_regs dut (.i_clock(clk), .i_sys_rst(rst), .i_control_clock(control_clock), .i_chip_select_n(chip_select_n),
        .i_control_data_in(cdi), .i_power_down_n(pdn_n), .i_channel_clock(ch_clk),
        .i_left_zero_cross(lzc), .i_right_zero_cross(rzc), .o_ctrl(ctrl), .o_gain_amp_on(gamp_on),
        .o_converter_on(conv_on), .o_all_powered_down(all_pd), .o_left_gain(lg), .o_right_gain(rg),
        .o_left_pending(lp), .o_right_pending(rp));

    always #10 clk = ~clk;
    // sample clock of 20 system cycles keeps timeouts short enough
    always @(posedge clk) begin
        ch_div <= (ch_div == 9) ? 0 : ch_div + 1;
        if (ch_div == 9) begin
            ch_clk <= ~ch_clk;
        end
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // decoded fields expected from the shadow bytes
    function automatic logic [12:0] exp_ctrl();
        return {sh[0][4:0], sh[1][0], sh[1][1], sh[2][7:4], sh[2][1], sh[3][7]};
    endfunction

    // one frame, then compare the decoded fields
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input bit take, input int edges = 16);
        host.send(a, d, edges);
        repeat (8) @(posedge clk);
        if (take) begin
            sh[a[1:0]] = d;
        end
        chk(16'(ctrl), 16'(exp_ctrl()));
    endtask

    task automatic t_reset();
        chk(16'(ctrl), 16'(exp_ctrl()));
        chk({all_pd, gamp_on, conv_on}, 3'b011);
        chk({lg, rg}, 14'h0000);
    endtask

    task automatic t_fields();
        // every mix, timeout and format code
        for (int i = 0; i < 4; i++) begin
            wr(5'h02, {2'(i), 2'(i), 2'b00, 1'(i), 1'b0}, 1);
        end
        wr(5'h00, 8'h0A, 1);
        wr(5'h00, 8'h15, 1);
    endtask

    task automatic t_refuse();
        wr(5'h04, 8'hFF, 0);
        wr(5'h1F, 8'hFF, 0);
        wr(5'h00, 8'hFF, 0, 15);
        wr(5'h00, 8'hFF, 0, 17);
    endtask

    task automatic t_gain_now();
        wr(5'h02, 8'h00, 1);
        wr(5'h03, 8'h28, 1);
        chk({lg, rg}, {7'h28, 7'h28});
        wr(5'h03, 8'h7F, 1);
        chk({lg, rg}, {7'h60, 7'h60});
        wr(5'h03, 8'h28, 1);
    endtask

    task automatic t_zero_cross();
        int n;
        wr(5'h03, 8'hB1, 1);
        chk({lg, rg, lp, rp}, {7'h28, 7'h28, 2'b11});
        @(posedge clk);
        lzc <= 1'b1;
        repeat (3) @(posedge clk);
        lzc <= 1'b0;
        repeat (3) @(posedge clk);
        chk({lg, rg, lp, rp}, {7'h31, 7'h28, 2'b01});
        wr(5'h03, 8'hB2, 1);
        chk({lg, rg, lp, rp}, {7'h31, 7'h28, 2'b11});
        n = 0;
        while (rp === 1'b1 && n < 6000) begin
            @(posedge clk);
            n++;
        end
        // 256 sample periods of 20 cycles from the restart
        chk(16'(n >= 5090 && n <= 5140), 16'h0001);
        repeat (2) @(posedge clk);
        chk({lg, rg, lp, rp}, {7'h32, 7'h32, 2'b00});
    endtask

    task automatic t_power();
        wr(5'h01, 8'h01, 1);
        chk({gamp_on, conv_on, all_pd}, 3'b100);
        wr(5'h02, 8'hC2, 0);
        // converter off, so the gain change applies at once
        wr(5'h03, 8'h85, 1);
        chk({lg, rg, lp, rp}, {7'h05, 7'h05, 2'b00});
        wr(5'h01, 8'h00, 1);
        chk({gamp_on, conv_on, all_pd}, 3'b001);
        wr(5'h03, 8'h10, 0);
        chk({lg, rg}, {7'h05, 7'h05});
        wr(5'h01, 8'h03, 1);
        chk({gamp_on, conv_on, all_pd}, 3'b110);
    endtask

    task automatic t_pin_down();
        @(posedge clk);
        pdn_n <= 1'b0;
        repeat (5) @(posedge clk);
        sh = '{8'h05, 8'h03, 8'h30, 8'h00};
        chk(16'(ctrl), 16'(exp_ctrl()));
        chk({all_pd, lg, rg}, 15'h4000);
        wr(5'h00, 8'h1F, 0);
        @(posedge clk);
        pdn_n <= 1'b1;
        repeat (5) @(posedge clk);
        // no power register write during calibration
        wr(5'h00, 8'h1F, 1);
    endtask

    initial begin
        sh = '{8'h05, 8'h03, 8'h30, 8'h00};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_fields();
        t_refuse();
        t_gain_now();
        t_zero_cross();
        t_power();
        t_pin_down();
        wrap_up();
    end
endmodule
`default_nettype wire
